// file: hdl/iowdt_pkg.sv
// constants, types and decode helpers of the read-controlled watchdog
package iowdt_pkg;
   // ---------------------------------------------------------------
   // port decode
   // ---------------------------------------------------------------
   localparam logic [15:0] ARM_PORT = 16'h0443;
   localparam logic [15:0] DIS_PORT = 16'h0043;

   // ---------------------------------------------------------------
   // timing
   // ---------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int CLK_HZ = 1000000000 / CLK_PERIOD_NS;
   localparam int TICK_TIME_S = 1;
   localparam int TICK_CYCLES = CLK_HZ * TICK_TIME_S;
   localparam int ACT_PULSE_NS = 1000;
   localparam int ACT_PULSE_CYCLES = (ACT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] ACT_PULSE_LAST = 8'(ACT_PULSE_CYCLES - 1);

   // ---------------------------------------------------------------
   // period selection, in seconds
   // ---------------------------------------------------------------
   localparam logic [7:0] PER0_S = 8'h01;
   localparam logic [7:0] PER1_S = 8'h02;
   localparam logic [7:0] PER2_S = 8'h0a;
   localparam logic [7:0] PER3_S = 8'h14;
   localparam logic [7:0] PER4_S = 8'h6e;
   localparam logic [7:0] PER5_S = 8'hdc;
   localparam logic [2:0] PER_RST = 3'h0;

   // ---------------------------------------------------------------
   // action selection
   // ---------------------------------------------------------------
   localparam logic [1:0] ACT_RESET = 2'h0;
   localparam logic [1:0] ACT_NMI = 2'h1;
   localparam logic [1:0] ACT_RST = ACT_RESET;
   localparam logic [7:0] RDATA_RST = 8'h00;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_RUN = 3'b010,
      ST_FIRE = 3'b100
   } iowdt_state_t;

   typedef struct packed {
      iowdt_state_t state;
      logic [7:0] sec_cnt;
      logic [7:0] pulse_cnt;
      logic [1:0] act_s1;
      logic [1:0] act_s2;
      logic [1:0] act_s3;
      logic [1:0] act_q;
      logic [2:0] per_s1;
      logic [2:0] per_s2;
      logic [2:0] per_s3;
      logic [2:0] per_q;
      logic rst_out;
      logic nmi_out;
      logic active;
      logic [7:0] rdata;
   } iowdt_regs_t;

   // unlisted codes fall back to the shortest period
   function automatic logic [7:0] iowdt_period_s(input logic [2:0] sel);
      case (sel)
         3'h1: iowdt_period_s = PER1_S;
         3'h2: iowdt_period_s = PER2_S;
         3'h3: iowdt_period_s = PER3_S;
         3'h4: iowdt_period_s = PER4_S;
         3'h5: iowdt_period_s = PER5_S;
         default: iowdt_period_s = PER0_S;
      endcase
   endfunction

   function automatic logic iowdt_act_on(input logic [1:0] act);
      iowdt_act_on = (act == ACT_RESET) || (act == ACT_NMI);
   endfunction
endpackage

// file: hdl/iowdt_tick_if.sv
// prescaler handshake between watchdog core and tick generator
`timescale 1ns/10ps
interface iowdt_tick_if;
   logic clr;
   logic tick;
   modport ctl (output clr, input tick);
   modport gen (input clr, output tick);
endinterface

// file: hdl/iowdt_presc.sv
// one-second tick generator, restartable from zero
`timescale 1ns/10ps
module iowdt_presc import iowdt_pkg::*; #(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // tick handshake
   iowdt_tick_if.gen bus
);
   localparam int CW = $clog2(TICK_CYCLES_P + 1);
   localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES_P - 1);

   typedef struct packed {
      logic [CW-1:0] cnt;
      logic tick;
   } iowdt_presc_t;

   iowdt_presc_t st;
   iowdt_presc_t next_st;

   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (bus.clr) begin
         next_st.cnt = '0;
      end else if (st.cnt == LAST) begin
         next_st.cnt = '0;
         next_st.tick = 1'b1;
      end else begin
         next_st.cnt = st.cnt + CW'(1);
      end
   end

   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign bus.tick = st.tick;
endmodule // iowdt_presc

// file: hdl/iowdt_top.sv
// watchdog driven purely by host I/O reads to two ports
// Functional notes
// - after power-on reset the watchdog is idle and produces no action.
// - a read of 0x443 while idle, with reset or NMI chosen, enables it and starts the period from zero.
// - a read of 0x043 disables it and suppresses any action.
// - a read of 0x443 while running restarts the period from zero.
// - counting past the period raises system reset or NMI per the action choice.
// - the action choice is reset (default), NMI, or off, and off never acts.
// - the period choice is 1, 2, 10, 20, 110 or 220 s, 1 s by default.
// - only reads of the two ports act; writes change nothing.
`timescale 1ns/10ps
module iowdt_top import iowdt_pkg::*; #(
   parameter int TICK_CYCLES_P = TICK_CYCLES
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic arst_n_i,
   // host i/o cycles
   input wire logic io_rd_i,
   input wire logic io_wr_i,
   input wire logic [15:0] io_addr_i,
   output logic [7:0] io_rdata_o,
   // static selections
   input wire logic [1:0] timeout_action_select_i,
   input wire logic [2:0] timeout_period_select_i,
   // actions
   output logic sys_reset_o,
   output logic nmi_o,
   output logic wdt_active_o
);
   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   iowdt_regs_t st;
   iowdt_regs_t next_st;
   iowdt_tick_if tick_bus ();

   logic arm_rd;
   logic dis_rd;
   logic [7:0] period;
   logic [7:0] sec_inc;
   logic act_on;

   assign arm_rd = io_rd_i && (io_addr_i == ARM_PORT);
   assign dis_rd = io_rd_i && (io_addr_i == DIS_PORT);
   assign period = iowdt_period_s(st.per_q);
   assign sec_inc = st.sec_cnt + 8'd1;
   assign act_on = iowdt_act_on(st.act_q);

   // prescaler held at zero unless running undisturbed
   // prescaled seconds
   assign tick_bus.clr = (st.state != ST_RUN) || arm_rd;

   iowdt_presc #(
      .TICK_CYCLES_P(TICK_CYCLES_P)
   ) u_presc (
      .clk_sys_i(clk_sys_i),
      .arst_n_i(arst_n_i),
      .bus(tick_bus.gen)
   );

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      next_st = st;
      // jumpers are asynchronous; take a change once stages two and three agree
      next_st.act_s1 = timeout_action_select_i;
      next_st.act_s2 = st.act_s1;
      next_st.act_s3 = st.act_s2;
      if (st.act_s2 == st.act_s3) begin
         next_st.act_q = st.act_s3;
      end
      next_st.per_s1 = timeout_period_select_i;
      next_st.per_s2 = st.per_s1;
      next_st.per_s3 = st.per_s2;
      if (st.per_s2 == st.per_s3) begin
         next_st.per_q = st.per_s3;
      end
      next_st.rdata = RDATA_RST;
      case (st.state)
         ST_IDLE: begin
            if (arm_rd && act_on) begin
               next_st.state = ST_RUN;
               next_st.sec_cnt = 8'd0;
            end
         end
         ST_RUN: begin
            if (dis_rd || !act_on) begin
               next_st.state = ST_IDLE;
            end else if (arm_rd) begin
               next_st.sec_cnt = 8'd0;
            end else if (tick_bus.tick) begin
               if (sec_inc >= period) begin
                  next_st.state = ST_FIRE;
                  next_st.pulse_cnt = 8'd0;
               end else begin
                  next_st.sec_cnt = sec_inc;
               end
            end
         end
         ST_FIRE: begin
            // action pulse ends idle; a disable cuts it short
            // off ends pulse
            if (dis_rd || !act_on || (st.pulse_cnt == ACT_PULSE_LAST)) begin
               next_st.state = ST_IDLE;
            end else begin
               next_st.pulse_cnt = st.pulse_cnt + 8'd1;
            end
         end
         default: begin
            next_st.state = ST_IDLE;
         end
      endcase
      next_st.rst_out = (next_st.state == ST_FIRE) && (st.act_q == ACT_RESET);
      next_st.nmi_out = (next_st.state == ST_FIRE) && (st.act_q == ACT_NMI);
      next_st.active = (next_st.state == ST_RUN);
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   // idle after reset
   always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         st.state <= ST_IDLE;
         st.sec_cnt <= 8'd0;
         st.pulse_cnt <= 8'd0;
         st.act_s1 <= ACT_RST;
         st.act_s2 <= ACT_RST;
         st.act_s3 <= ACT_RST;
         st.act_q <= ACT_RST;
         st.per_s1 <= PER_RST;
         st.per_s2 <= PER_RST;
         st.per_s3 <= PER_RST;
         st.per_q <= PER_RST;
         st.rst_out <= 1'b0;
         st.nmi_out <= 1'b0;
         st.active <= 1'b0;
         st.rdata <= RDATA_RST;
      end else begin
         st <= next_st;
      end
   end

   assign io_rdata_o = st.rdata;
   assign sys_reset_o = st.rst_out;
   assign nmi_o = st.nmi_out;
   assign wdt_active_o = st.active;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   idle_quiet_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_IDLE |-> !sys_reset_o && !nmi_o && !wdt_active_o)
      else $error("idle watchdog drives an output");

   arm_start_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_IDLE && arm_rd && act_on |=> wdt_active_o && st.sec_cnt == 8'd0)
      else $error("enable read did not start the count");

   disarm_stop_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      dis_rd |=> st.state == ST_IDLE && !sys_reset_o && !nmi_o)
      else $error("disable read did not stop the watchdog");

   refresh_clear_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_RUN && arm_rd && !dis_rd && act_on |=> wdt_active_o && st.sec_cnt == 8'd0)
      else $error("refresh did not restart the count");

   reset_fire_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_RUN && tick_bus.tick && !io_rd_i && sec_inc >= period
      && st.act_q == ACT_RESET |=> (sys_reset_o && !nmi_o) [*8])
      else $error("timeout did not hold system reset");

   nmi_fire_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_RUN && tick_bus.tick && !io_rd_i && sec_inc >= period
      && st.act_q == ACT_NMI |=> nmi_o && !sys_reset_o)
      else $error("timeout did not raise nmi");

   act_off_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      !act_on && !$past(act_on) |-> st.state == ST_IDLE && !sys_reset_o && !nmi_o)
      else $error("watchdog acts while switched off");

   period_bound_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_RUN |-> st.sec_cnt < period)
      else $error("second count passed the period");

   write_ignored_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_IDLE && io_wr_i && !io_rd_i |=> st.state == ST_IDLE)
      else $error("write changed the watchdog state");

   rdata_zero_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      io_rd_i |=> io_rdata_o == 8'h00)
      else $error("read data not zero");

   idle_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_IDLE && !arm_rd |=> st.state == ST_IDLE)
      else $error("idle watchdog left idle without an enable read");

   count_hold_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_RUN && !io_rd_i && !tick_bus.tick && act_on
      |=> st.state == ST_RUN && $stable(st.sec_cnt))
      else $error("count moved without a read or a tick");

   tick_only_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_RUN && !tick_bus.tick |=> st.state != ST_FIRE)
      else $error("timeout raised between second ticks");

   pulse_end_a: assert property (@(posedge clk_sys_i) disable iff (!arst_n_i)
      st.state == ST_FIRE && st.pulse_cnt == ACT_PULSE_LAST |=> st.state == ST_IDLE)
      else $error("action pulse did not end");
endmodule // iowdt_top

// file: test/iowdt_host.sv
// host model issuing single-cycle i/o read and write strobes
`timescale 1ns/10ps
module iowdt_host (
   // clock
   input wire logic clk_sys_i,
   // i/o cycles
   output logic io_rd_o,
   output logic io_wr_o,
   output logic [15:0] io_addr_o
);
   initial begin
      io_rd_o = 1'b0;
      io_wr_o = 1'b0;
      io_addr_o = 16'hffff;
   end

   // ---------------------------------------------------------------
   // bus cycle
   // ---------------------------------------------------------------
   // released address is inverted so a stale decode cannot pass
   task automatic cycle(input logic wr, input logic [15:0] addr);
      @(negedge clk_sys_i);
      io_addr_o = addr;
      if (wr) io_wr_o = 1'b1;
      else io_rd_o = 1'b1;
      @(negedge clk_sys_i);
      io_rd_o = 1'b0;
      io_wr_o = 1'b0;
      io_addr_o = ~addr;
   endtask
endmodule // iowdt_host

// file: test/test_io_read_watchdog_timer.sv
// self-checking bench of the read-controlled watchdog
`timescale 1ns/10ps
module test_io_read_watchdog_timer import iowdt_pkg::*;;
   // short prescaler keeps the 220 s case near 2200 cycles
   localparam int TICK = 10;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic io_rd, io_wr, sys_rst, nmi, active;
   logic [15:0] io_addr;
   logic [7:0] rdata;
   logic [1:0] act_sel = ACT_RESET;
   logic [2:0] per_sel = 3'h0;
   int bad_count = 0;
   int tests_run = 0;
   int n;
   int secs[8] = '{1, 2, 10, 20, 110, 220, 1, 1};

   always #5 clk = ~clk;

   iowdt_host host (.clk_sys_i(clk), .io_rd_o(io_rd), .io_wr_o(io_wr), .io_addr_o(io_addr));
   iowdt_top #(.TICK_CYCLES_P(TICK)) dut (.clk_sys_i(clk), .arst_n_i(arst_n), .io_rd_i(io_rd),
      .io_wr_i(io_wr), .io_addr_i(io_addr), .io_rdata_o(rdata),
      .timeout_action_select_i(act_sel), .timeout_period_select_i(per_sel),
      .sys_reset_o(sys_rst), .nmi_o(nmi), .wdt_active_o(active));

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   task automatic report_and_stop;
      if (bad_count == 0 && tests_run > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic check_val(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic check_cnt(input int got, input int lo, input int hi);
      tests_run++;
      if (got < lo || got > hi) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h..%h", $time, got, lo, hi);
      end
   endtask

   task automatic wait_fire(input int limit);
      n = 0;
      while (sys_rst !== 1'b1 && nmi !== 1'b1 && n < limit) begin
         @(negedge clk);
         n++;
      end
   endtask

   task automatic drain_pulse;
      n = 0;
      while ((sys_rst === 1'b1 || nmi === 1'b1) && n < 300) begin
         @(negedge clk);
         n++;
      end
   endtask

   // jumpers pass a three-flop synchroniser before use
   task automatic set_sel(input logic [1:0] a, input logic [2:0] p);
      @(negedge clk);
      act_sel = a;
      per_sel = p;
      repeat (8) @(negedge clk);
   endtask

   // ---------------------------------------------------------------
   // scenarios
   // ---------------------------------------------------------------
   task automatic t_periods;
      for (int i = 0; i < 8; i++) begin
         set_sel(ACT_RESET, 3'(i));
         host.cycle(1'b0, ARM_PORT);
         @(negedge clk);
         check_val(active, 1'b1);
         wait_fire(3000);
         check_cnt(n + 1, secs[i] * TICK - 1, secs[i] * TICK + 3);
         check_val({sys_rst, nmi, active}, 3'b100);
         drain_pulse();
         check_cnt(n, ACT_PULSE_CYCLES, ACT_PULSE_CYCLES);
      end
   endtask

   task automatic t_refresh;
      set_sel(ACT_RESET, 3'h1);
      host.cycle(1'b0, ARM_PORT);
      repeat (15) @(negedge clk);
      host.cycle(1'b0, ARM_PORT);
      wait_fire(100);
      check_cnt(n, 2 * TICK - 1, 2 * TICK + 3);
      drain_pulse();
   endtask

   task automatic t_disable;
      set_sel(ACT_RESET, 3'h0);
      host.cycle(1'b0, DIS_PORT);
      host.cycle(1'b0, ARM_PORT);
      host.cycle(1'b0, DIS_PORT);
      @(negedge clk);
      check_val(active, 1'b0);
      wait_fire(5 * TICK);
      check_cnt(n, 5 * TICK, 5 * TICK);
      check_val(rdata, 8'h00);
      // a disable during the action pulse cuts it short
      host.cycle(1'b0, ARM_PORT);
      wait_fire(3 * TICK);
      host.cycle(1'b0, DIS_PORT);
      @(negedge clk);
      check_val({sys_rst, nmi, active}, 3'b000);
   endtask

   task automatic t_reset;
      set_sel(ACT_RESET, 3'h0);
      host.cycle(1'b0, ARM_PORT);
      repeat (4) @(negedge clk);
      arst_n = 1'b0;
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      check_val({sys_rst, nmi, active}, 3'b000);
      wait_fire(3 * TICK);
      check_cnt(n, 3 * TICK, 3 * TICK);
   endtask

   task automatic t_actions;
      set_sel(ACT_NMI, 3'h0);
      host.cycle(1'b0, ARM_PORT);
      wait_fire(3 * TICK);
      check_val({sys_rst, nmi}, 2'b01);
      drain_pulse();
      for (int a = 2; a < 4; a++) begin
         set_sel(2'(a), 3'h0);
         host.cycle(1'b0, ARM_PORT);
         wait_fire(5 * TICK);
         check_cnt(n, 5 * TICK, 5 * TICK);
         check_val(active, 1'b0);
      end
   endtask

   task automatic t_writes;
      set_sel(ACT_RESET, 3'h0);
      host.cycle(1'b1, ARM_PORT);
      host.cycle(1'b0, 16'h0433);
      wait_fire(3 * TICK);
      check_cnt(n, 3 * TICK, 3 * TICK);
      host.cycle(1'b0, ARM_PORT);
      host.cycle(1'b1, DIS_PORT);
      wait_fire(3 * TICK);
      check_val(sys_rst, 1'b1);
      drain_pulse();
   endtask

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (3) @(negedge clk);
      arst_n = 1'b1;
      repeat (50) @(negedge clk);
      check_val({sys_rst, nmi, active}, 3'b000);
      t_periods();
      t_refresh();
      t_disable();
      t_actions();
      t_writes();
      t_reset();
      report_and_stop();
   end

   // whole run is near 5300 cycles
   initial begin
      #200us;
      bad_count++;
      report_and_stop();
   end
endmodule // test_io_read_watchdog_timer
